// *** rtl/icsr_top.sv ***
// Command and status registers of the vectored interrupt controller.
// Assumes an AHB-Lite master on hclk, source requests and priorities from
// the rest of the controller on the same clock, and one core listening.
`timescale 1ns/100ps
`include "icsr_consts.svh"
module icsr_top #(
    parameter int LVL_W = 3,
    parameter int STK_DEPTH = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Sources from the rest of the controller
    input wire logic [31:0] src_request,
    input wire logic [32*LVL_W-1:0] src_priority,
    // Core request lines, active high here
    output logic fast_request_line,
    output logic normal_request_line,
    // Event interrupt
    output logic irq_out
);
    localparam int AW = $clog2(STK_DEPTH);
    localparam int SW = LVL_W + 1;

    function automatic logic outranks(input logic cv, input logic [LVL_W-1:0] cp,
                                      input logic nv, input logic [LVL_W-1:0] np);
        return nv && (!cv || np > cp);
    endfunction : outranks

    // ==========================================
    // Bus decode
    logic [31:0] enabled;
    logic [31:0] pending;
    logic [31:0] spurious;
    logic [31:0] evt_status;
    logic [31:0] evt_mask;
    logic cur_valid;
    logic [LVL_W-1:0] cur_prio;
    logic [4:0] cur_src;
    logic [AW:0] depth;
    logic [AW:0] next_depth;
    logic dp_write;
    icsr_pkg::icsr_reg_type dp_reg;
    icsr_pkg::icsr_reg_type ap_reg;
    logic accept;
    logic rd_now;
    logic vec_read;
    logic evt_read;
    logic eoi;
    logic [31:0] cmd_en;
    logic [31:0] cmd_dis;
    logic [31:0] cmd_clr;
    logic [31:0] cmd_set;
    logic cand_valid;
    logic [4:0] cand_id;
    logic [LVL_W-1:0] cand_lvl;
    logic take;
    logic next_fast;
    logic next_normal;
    logic [31:0] rd_mux;

    assign accept = hsel && htrans[1] && hready;
    assign ap_reg = icsr_pkg::icsr_decode(haddr[7:0]);
    assign rd_now = accept && !hwrite;
    assign vec_read = rd_now && ap_reg == icsr_pkg::ICSR_R_VECTOR;
    assign evt_read = rd_now && ap_reg == icsr_pkg::ICSR_R_EVST;
    assign eoi = dp_write && dp_reg == icsr_pkg::ICSR_R_EOI;
    assign cmd_en = (dp_write && dp_reg == icsr_pkg::ICSR_R_ENABLE) ? hwdata : '0;
    assign cmd_dis = (dp_write && dp_reg == icsr_pkg::ICSR_R_DISABLE) ? hwdata : '0;
    assign cmd_clr = (dp_write && dp_reg == icsr_pkg::ICSR_R_CLEAR) ? hwdata : '0;
    assign cmd_set = (dp_write && dp_reg == icsr_pkg::ICSR_R_SET) ? hwdata : '0;

    // Zero wait states, so a data phase always ends at the next edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_reg <= icsr_pkg::ICSR_R_NONE;
        end else begin
            dp_write <= accept && hwrite;
            dp_reg <= accept ? ap_reg : icsr_pkg::ICSR_R_NONE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ==========================================
    // Enable and pending state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enabled <= `ICSR_RST_WORD;
        end else begin
            enabled <= (enabled & ~cmd_dis) | cmd_en;
        end
    end

    // A request arriving with a clear survives it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending <= `ICSR_RST_WORD;
        end else begin
            pending <= (pending & ~cmd_clr) | cmd_set | src_request;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spurious <= `ICSR_RST_SPURIOUS;
        end else if (dp_write && dp_reg == icsr_pkg::ICSR_R_SPUR) begin
            spurious <= hwdata;
        end
    end

    // ==========================================
    // Arbitration and level stack
    icsr_prio_pick #(.LVL_W(LVL_W)) u_pick (
        .active(pending & enabled),
        .prio(src_priority),
        .valid(cand_valid),
        .id(cand_id),
        .lvl(cand_lvl)
    );

    icsr_stk_if #(.W(SW), .AW(AW)) stk ();

    icsr_level_stack #(.W(SW), .DEPTH(STK_DEPTH)) u_stack (
        .hclk(hclk),
        .hresetn(hresetn),
        .stk(stk)
    );

    // A vector read only acts when a source outranks the current level
    assign take = vec_read && outranks(cur_valid, cur_prio, cand_valid, cand_lvl);

    always_comb begin
        next_depth = depth;
        if (take && !eoi && depth != (AW+1)'(STK_DEPTH)) begin
            next_depth = depth + 1'b1;
        end else if (eoi && !take && depth != '0) begin
            next_depth = depth - 1'b1;
        end
    end

    // Full stack drops the new push silently
    assign stk.push = take && !eoi && depth != (AW+1)'(STK_DEPTH);
    assign stk.waddr = depth[AW-1:0];
    assign stk.wdata = {cur_valid, cur_prio};
    assign stk.raddr = next_depth[AW-1:0] - 1'b1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            depth <= '0;
        end else begin
            depth <= next_depth;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_valid <= 1'b0;
            cur_prio <= '0;
            cur_src <= 5'h00;
        end else if (take) begin
            cur_valid <= 1'b1;
            cur_prio <= cand_lvl;
            cur_src <= cand_id;
        end else if (eoi) begin
            if (depth != '0) begin
                {cur_valid, cur_prio} <= stk.rdata;
            end else begin
                cur_valid <= 1'b0;
                cur_prio <= '0;
            end
            cur_src <= 5'h00;
        end
    end

    // ==========================================
    // Core request lines
    // bit 0 is fast
    assign next_fast = enabled[`ICSR_BIT_FAST] && pending[`ICSR_BIT_FAST];
    // raise when outranked, drop on read
    assign next_normal = outranks(cur_valid, cur_prio, cand_valid, cand_lvl) && !vec_read;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_request_line <= 1'b0;
            normal_request_line <= 1'b0;
        end else begin
            fast_request_line <= next_fast;
            normal_request_line <= next_normal;
        end
    end

    // ==========================================
    // Event status and interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_status <= `ICSR_RST_WORD;
        end else begin
            evt_status <= (evt_read ? `ICSR_RST_WORD : evt_status)
                          | {30'h0, next_normal && !normal_request_line,
                             next_fast && !fast_request_line};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_mask <= `ICSR_RST_WORD;
        end else if (dp_write && dp_reg == icsr_pkg::ICSR_R_EVMASK) begin
            evt_mask <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(evt_status & evt_mask);
        end
    end

    // ==========================================
    // Read data, valid through the data phase
    always_comb begin
        case (ap_reg)
            icsr_pkg::ICSR_R_CORE: rd_mux = {30'h0, normal_request_line, fast_request_line};
            icsr_pkg::ICSR_R_SPUR: rd_mux = spurious;
            icsr_pkg::ICSR_R_VECTOR: rd_mux = take ? {27'h0, cand_id} : spurious;
            icsr_pkg::ICSR_R_MASK: rd_mux = enabled;
            icsr_pkg::ICSR_R_PEND: rd_mux = pending;
            icsr_pkg::ICSR_R_EVST: rd_mux = evt_status;
            icsr_pkg::ICSR_R_EVMASK: rd_mux = evt_mask;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= rd_now ? rd_mux : 32'h0000_0000;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_fast_line_follows: assert property (
        next_fast |=> fast_request_line)
        else $error("fast line not raised");
    a_fast_line_drops: assert property (
        !next_fast |=> !fast_request_line)
        else $error("fast line not dropped");
    a_core_status_bits: assert property (
        rd_now && ap_reg == icsr_pkg::ICSR_R_CORE
        |=> hrdata[1:0] == {$past(normal_request_line), $past(fast_request_line)})
        else $error("core status mismatch");
    a_enable_cmd_sets: assert property (
        cmd_en != '0 |=> (enabled & $past(cmd_en)) == $past(cmd_en)
                         && (enabled & ~$past(cmd_en)) == ($past(enabled) & ~$past(cmd_en)))
        else $error("enable command wrong");
    a_disable_cmd_clears: assert property (
        cmd_dis != '0 |=> (enabled & $past(cmd_dis)) == '0
                          && (enabled & ~$past(cmd_dis)) == ($past(enabled) & ~$past(cmd_dis)))
        else $error("disable command wrong");
    a_clear_cmd_works: assert property (
        cmd_clr != '0 |=> (pending & $past(cmd_clr) & ~$past(src_request)) == '0)
        else $error("clear command wrong");
    a_set_cmd_works: assert property (
        cmd_set != '0 |=> (pending & $past(cmd_set)) == $past(cmd_set))
        else $error("set command wrong");
    a_spurious_write: assert property (
        dp_write && dp_reg == icsr_pkg::ICSR_R_SPUR |=> spurious == $past(hwdata))
        else $error("spurious word not stored");
    a_eoi_pops: assert property (
        eoi && !take && depth != '0 |=> depth == $past(depth) - 1'b1
        && {cur_valid, cur_prio} == $past(stk.rdata))
        else $error("end of interrupt did not pop");
    a_eoi_empty_stack: assert property (
        eoi && !take && depth == '0 |=> !cur_valid && depth == '0)
        else $error("end of interrupt on empty stack kept a level");
    a_normal_line_raise: assert property (
        next_normal |=> normal_request_line)
        else $error("normal line not raised");
    a_vector_take: assert property (
        take |=> !normal_request_line && cur_src == $past(cand_id) && cur_valid)
        else $error("vector read did not take source");
    a_mask_view_read: assert property (
        rd_now && ap_reg == icsr_pkg::ICSR_R_MASK |=> hrdata == $past(enabled))
        else $error("mask view mismatch");
    a_irq_level: assert property (
        |(evt_status & evt_mask) |=> irq_out)
        else $error("interrupt output low");

    c_nested_take: cover property (take && cur_valid);
    c_eoi_repost: cover property (eoi ##1 next_normal);
    c_spurious_read: cover property (vec_read && !take);
    c_fast_event: cover property (fast_request_line && irq_out);
endmodule : icsr_top

// *** rtl/icsr_consts.svh ***
// Offsets, bit positions and reset values of the interrupt command block.
// Assumes byte addresses on a 32-bit bus, one aligned word per register.
`ifndef ICSR_CONSTS_SVH
`define ICSR_CONSTS_SVH
// ==========================================
// Register byte offsets
`define ICSR_OFS_CORE_STATUS 8'h00
`define ICSR_OFS_ENABLE_CMD 8'h04
`define ICSR_OFS_DISABLE_CMD 8'h08
`define ICSR_OFS_CLEAR_CMD 8'h0C
`define ICSR_OFS_SET_CMD 8'h10
`define ICSR_OFS_EOI_CMD 8'h14
`define ICSR_OFS_SPURIOUS 8'h18
`define ICSR_OFS_VECTOR 8'h1C
`define ICSR_OFS_MASK_VIEW 8'h20
`define ICSR_OFS_PENDING 8'h24
`define ICSR_OFS_EVT_STATUS 8'h28
`define ICSR_OFS_EVT_MASK 8'h2C
// ==========================================
// Bit map shared by all command words
`define ICSR_NUM_SRC 32
`define ICSR_BIT_FAST 0
`define ICSR_BIT_NORMAL 1
`define ICSR_BIT_SOFTWARE 1
`define ICSR_FIRST_NORMAL 1
// ==========================================
// Reset values
`define ICSR_RST_SPURIOUS 32'h0000_0000
`define ICSR_RST_WORD 32'h0000_0000
`endif

// *** rtl/icsr_pkg.sv ***
// Types and address decoding for the interrupt command block.
// Assumes the constants header is on the include path.
`include "icsr_consts.svh"
package icsr_pkg;
    typedef enum {
        ICSR_R_NONE, ICSR_R_CORE, ICSR_R_ENABLE, ICSR_R_DISABLE, ICSR_R_CLEAR,
        ICSR_R_SET, ICSR_R_EOI, ICSR_R_SPUR, ICSR_R_VECTOR, ICSR_R_MASK,
        ICSR_R_PEND, ICSR_R_EVST, ICSR_R_EVMASK
    } icsr_reg_type;

    function automatic icsr_reg_type icsr_decode(input logic [7:0] a);
        case (a)
            `ICSR_OFS_CORE_STATUS: return ICSR_R_CORE;
            `ICSR_OFS_ENABLE_CMD: return ICSR_R_ENABLE;
            `ICSR_OFS_DISABLE_CMD: return ICSR_R_DISABLE;
            `ICSR_OFS_CLEAR_CMD: return ICSR_R_CLEAR;
            `ICSR_OFS_SET_CMD: return ICSR_R_SET;
            `ICSR_OFS_EOI_CMD: return ICSR_R_EOI;
            `ICSR_OFS_SPURIOUS: return ICSR_R_SPUR;
            `ICSR_OFS_VECTOR: return ICSR_R_VECTOR;
            `ICSR_OFS_MASK_VIEW: return ICSR_R_MASK;
            `ICSR_OFS_PENDING: return ICSR_R_PEND;
            `ICSR_OFS_EVT_STATUS: return ICSR_R_EVST;
            `ICSR_OFS_EVT_MASK: return ICSR_R_EVMASK;
            default: return ICSR_R_NONE;
        endcase
    endfunction : icsr_decode
endpackage : icsr_pkg

// *** rtl/icsr_stk_if.sv ***
// Port bundle between the level stack control and its storage.
// Assumes one clock; read data is registered in the storage.
`timescale 1ns/100ps
interface icsr_stk_if #(parameter int W = 4, parameter int AW = 3);
    logic push;
    logic [AW-1:0] waddr;
    logic [W-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [W-1:0] rdata;
    modport ctl (output push, output waddr, output wdata, output raddr, input rdata);
    modport mem (input push, input waddr, input wdata, input raddr, output rdata);
endinterface : icsr_stk_if

// *** rtl/icsr_level_stack.sv ***
// Storage for saved priority levels, registered read with write bypass.
// Assumes the controller keeps the depth count and never reads past it.
`timescale 1ns/100ps
module icsr_level_stack #(
    parameter int W = 4,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Stack port
    icsr_stk_if.mem stk
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge hclk) begin
        if (stk.push) begin
            mem[stk.waddr] <= stk.wdata;
        end
    end

    // Bypass so a push is visible as the top on the very next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stk.rdata <= '0;
        end else if (stk.push && stk.waddr == stk.raddr) begin
            stk.rdata <= stk.wdata;
        end else begin
            stk.rdata <= mem[stk.raddr];
        end
    end
endmodule : icsr_level_stack

// *** rtl/icsr_prio_pick.sv ***
// Finds the highest-priority active normal source.
// Assumes bit 0 is the fast source and is left out; ties go to the lower number.
`timescale 1ns/100ps
`include "icsr_consts.svh"
module icsr_prio_pick #(
    parameter int LVL_W = 3
) (
    // Candidates
    input wire logic [31:0] active,
    input wire logic [32*LVL_W-1:0] prio,
    // Winner
    output logic valid,
    output logic [4:0] id,
    output logic [LVL_W-1:0] lvl
);
    always_comb begin
        valid = 1'b0;
        id = 5'h00;
        lvl = '0;
        for (int i = `ICSR_FIRST_NORMAL; i < `ICSR_NUM_SRC; i++) begin
            if (active[i] && (!valid || prio[i*LVL_W +: LVL_W] > lvl)) begin
                valid = 1'b1;
                id = 5'(i);
                lvl = prio[i*LVL_W +: LVL_W];
            end
        end
    end
endmodule : icsr_prio_pick

// *** tb/icsr_core_model.sv ***
// Stand-in for the core's fast and normal request inputs.
// Assumes both lines are registered on hclk and active high.
`timescale 1ns/100ps
module icsr_core_model (
    // Clock
    input wire logic hclk,
    // Request lines from the block
    input wire logic fast_request_line,
    input wire logic normal_request_line,
    // Rise counts seen by the core
    output int fast_rises,
    output int normal_rises
);
    logic fast_q = 1'b0;
    logic norm_q = 1'b0;
    initial begin
        fast_rises = 0;
        normal_rises = 0;
    end
    // ==========================================
    // Edge counting
    // Only rises matter: the core starts a sequence on each new request
    always @(posedge hclk) begin
        fast_q <= fast_request_line;
        norm_q <= normal_request_line;
        if (fast_request_line === 1'b1 && fast_q === 1'b0) begin
            fast_rises <= fast_rises + 1;
        end
        if (normal_request_line === 1'b1 && norm_q === 1'b0) begin
            normal_rises <= normal_rises + 1;
        end
    end
endmodule : icsr_core_model

// *** tb/tb.sv ***
// Self-checking bench for the interrupt command and status registers.
// Assumes one AHB-Lite master, zero wait states and the core model.
`timescale 1ns/100ps
`include "icsr_consts.svh"
module tb;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic hclk, hresetn, hsel, hwrite, hready;
    logic [31:0] haddr, hwdata, hrdata, src_request;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [95:0] src_priority;
    logic hreadyout, hresp, fast_request_line, normal_request_line, irq_out;
    logic dph_rd = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] a, b, c, m;
    int fast_rises, normal_rises, n_mismatch, check_count, base;
    assign hready = hreadyout;
    icsr_top #(.LVL_W(3), .STK_DEPTH(8)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .src_request(src_request), .src_priority(src_priority),
        .fast_request_line(fast_request_line),
        .normal_request_line(normal_request_line), .irq_out(irq_out));
    icsr_core_model core (
        .hclk(hclk), .fast_request_line(fast_request_line),
        .normal_request_line(normal_request_line),
        .fast_rises(fast_rises), .normal_rises(normal_rises));
    // ==========================================
    // Compare and bus tasks
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_line(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: line %h expected %h", $time, got, exp);
        end
    endtask : chk_line
    // Each phase holds until ready is sampled high at a rising edge
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h00_0000, ad};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask : bus
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d);
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] mk);
        exp_q.push_back(e & mk);
        msk_q.push_back(mk);
        bus(1'b0, ad, 32'h0000_0000);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle
    task automatic end_sim();
        $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    // ==========================================
    // Result watcher: pops the oldest note at each read data phase
    always @(posedge hclk) begin
        if (dph_rd && hreadyout === 1'b1) begin
            m = msk_q.pop_front();
            chk_word(hrdata & m, exp_q.pop_front());
            chk_line(hresp, 1'b0);
        end
        dph_rd <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
    end
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Whole run is about 140 cycles; this is far beyond it
    initial begin
        #200us;
        n_mismatch++;
        end_sim();
    end
    // ==========================================
    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        src_request = 32'h0000_0000;
        src_priority = 96'h0;
        src_priority[11:9] = 3'h2;
        src_priority[17:15] = 3'h6;
        n_mismatch = 0;
        check_count = 0;
        void'($urandom(25));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`ICSR_OFS_CORE_STATUS, 32'h0, ALL);
        rd(`ICSR_OFS_SPURIOUS, 32'h0, ALL);
        rd(`ICSR_OFS_MASK_VIEW, 32'h0, ALL);
        rd(8'hF0, 32'h0, ALL);
        a = $urandom();
        wr(`ICSR_OFS_SPURIOUS, a);
        rd(`ICSR_OFS_SPURIOUS, a, ALL);
        rd(`ICSR_OFS_ENABLE_CMD, 32'h0, ALL);
        a = $urandom();
        b = $urandom();
        c = $urandom();
        wr(`ICSR_OFS_ENABLE_CMD, a);
        rd(`ICSR_OFS_MASK_VIEW, a, ALL);
        wr(`ICSR_OFS_ENABLE_CMD, b);
        rd(`ICSR_OFS_MASK_VIEW, a | b, ALL);
        wr(`ICSR_OFS_DISABLE_CMD, c);
        rd(`ICSR_OFS_MASK_VIEW, (a | b) & ~c, ALL);
        wr(`ICSR_OFS_DISABLE_CMD, ALL);
        wr(`ICSR_OFS_CLEAR_CMD, ALL);
        rd(`ICSR_OFS_PENDING, 32'h0, ALL);
        wr(`ICSR_OFS_SET_CMD, a);
        rd(`ICSR_OFS_PENDING, a, ALL);
        wr(`ICSR_OFS_CLEAR_CMD, b);
        src_request <= c;
        @(posedge hclk);
        src_request <= 32'h0000_0000;
        rd(`ICSR_OFS_PENDING, (a & ~b) | c, ALL);
        // Fast source alone, with the event interrupt
        rd(`ICSR_OFS_EVT_STATUS, 32'h0, ALL);
        wr(`ICSR_OFS_CLEAR_CMD, ALL);
        wr(`ICSR_OFS_ENABLE_CMD, 32'h0000_0001);
        wr(`ICSR_OFS_SET_CMD, 32'h0000_0001);
        idle(2);
        chk_line(fast_request_line, 1'b1);
        rd(`ICSR_OFS_CORE_STATUS, 32'h1, ALL);
        chk_line(irq_out, 1'b0);
        wr(`ICSR_OFS_EVT_MASK, 32'h0000_0001);
        idle(2);
        chk_line(irq_out, 1'b1);
        rd(`ICSR_OFS_EVT_STATUS, 32'h1, 32'h1);
        idle(2);
        chk_line(irq_out, 1'b0);
        wr(`ICSR_OFS_CLEAR_CMD, 32'h0000_0001);
        idle(2);
        rd(`ICSR_OFS_CORE_STATUS, 32'h0, ALL);
        // Nested normal sources 3 (level 2) and 5 (level 6)
        wr(`ICSR_OFS_DISABLE_CMD, ALL);
        wr(`ICSR_OFS_CLEAR_CMD, ALL);
        wr(`ICSR_OFS_ENABLE_CMD, 32'h0000_0028);
        idle(2);
        base = normal_rises;
        wr(`ICSR_OFS_SET_CMD, 32'h0000_0008);
        idle(2);
        rd(`ICSR_OFS_CORE_STATUS, 32'h2, ALL);
        rd(`ICSR_OFS_VECTOR, 32'h3, ALL);
        idle(2);
        rd(`ICSR_OFS_CORE_STATUS, 32'h0, ALL);
        wr(`ICSR_OFS_CLEAR_CMD, 32'h0000_0008);
        wr(`ICSR_OFS_SET_CMD, 32'h0000_0020);
        idle(2);
        chk_line(normal_request_line, 1'b1);
        rd(`ICSR_OFS_VECTOR, 32'h5, ALL);
        wr(`ICSR_OFS_CLEAR_CMD, 32'h0000_0020);
        wr(`ICSR_OFS_SET_CMD, 32'h0000_0008);
        idle(2);
        rd(`ICSR_OFS_CORE_STATUS, 32'h0, ALL);
        wr(`ICSR_OFS_EOI_CMD, $urandom());
        idle(2);
        rd(`ICSR_OFS_CORE_STATUS, 32'h0, ALL);
        wr(`ICSR_OFS_EOI_CMD, $urandom());
        idle(2);
        rd(`ICSR_OFS_CORE_STATUS, 32'h2, ALL);
        rd(`ICSR_OFS_VECTOR, 32'h3, ALL);
        chk_word(32'(normal_rises - base), 32'h3);
        chk_word(32'(fast_rises), 32'h1);
        idle(2);
        end_sim();
    end
endmodule : tb
